// >>> fan_adapt_regs.svh
// Register map, field positions and reset values of the fan threshold block.
// Assumes an 8-bit register address space and 8-bit signed temperatures.
// How it works
// - An adapted turn-on threshold never goes below -127 degrees; it saturates there.
// - An adapted turn-on threshold never rises above the channel high limit.
// - Below its threshold a channel holds its fan off and stops adapting.
// - Control bit 2 plus an alert copies far-2 temperature to its operating point.
// - With a capture bit clear, alerts leave that operating point as software wrote it.
// - Control bit 3 plus an alert copies near temperature to its operating point.
// - Control bit 4 plus an alert copies far-1 temperature to its operating point.
// - Control bit 5 enables far-2 adaptation from temperature, operating point and limits.
// - Control bit 6 enables near-channel adaptation the same way.
// - Control bit 7 enables far-1 adaptation the same way.
// - With adaptation off the threshold is never changed by hardware.
// - The alert input counts as asserted while driven low.
// - Without ramping an output takes each new duty target at once.
// - With ramping an output changes by a limited amount per update.
// - Each ramped update moves one step toward target; falls start immediately.
// - Ramping is chosen per output, independent of shared temperature sources.
// - Ramp control one bit 3 enables ramping on fan drive 1.
// - Ramp control two bit 7 enables ramping on fan drive 2.
// - Ramp control two bit 3 enables ramping on fan drive 3.
// - Duty is counted in slots of 1/255 period; steps are in slots.
// - A 3-bit code picks 1, 2, 3, 5, 8, 12, 24 or 48 slots per step.
// - Each stepped duty value is kept as the base for the next comparison.
`ifndef FAN_ADAPT_REGS_SVH
`define FAN_ADAPT_REGS_SVH

// Register offsets
`define ADDR_ADAPT_CTRL  8'h36
`define ADDR_RAMP_ONE    8'h62
`define ADDR_RAMP_TWO    8'h63
`define ADDR_LIM_LO_F1   8'h4E
`define ADDR_LIM_HI_F1   8'h4F
`define ADDR_LIM_LO_NR   8'h50
`define ADDR_LIM_HI_NR   8'h51
`define ADDR_LIM_LO_F2   8'h52
`define ADDR_LIM_HI_F2   8'h53
`define ADDR_OP_BASE     8'h80
`define ADDR_THR_BASE    8'h83
`define ADDR_STATUS      8'h86
`define ADDR_DUTY_BASE   8'h87

// Control field positions, channel 0 far 1, 1 near, 2 far 2
`define BIT_CAP_F2       2
`define BIT_CAP_NR       3
`define BIT_CAP_F1       4
`define BIT_ADP_F2       5
`define BIT_ADP_NR       6
`define BIT_ADP_F1       7
`define BIT_RAMP_EN_LO   3
`define BIT_RAMP_EN_HI   7
`define FLD_STEP_LO      2:0
`define FLD_STEP_HI      6:4

// Values
`define TEMP_FLOOR       8'h81
`define LIM_LO_RESET     8'h81
`define LIM_HI_RESET     8'h7F
`define OP_RESET         8'h7F
`define THR_RESET        8'h5A
`define DUTY_FULL        8'hFF
`define THR_STEP         8'h01

// Ramp step sizes in slots, one per step code
`define STEP_0           8'h01
`define STEP_1           8'h02
`define STEP_2           8'h03
`define STEP_3           8'h05
`define STEP_4           8'h08
`define STEP_5           8'h0C
`define STEP_6           8'h18
`define STEP_7           8'h30

`endif

// >>> fan_adapt_pkg.sv
// Types shared by the fan threshold block.
// Assumes three temperature channels and three fan drives.
package fan_adapt_pkg;
    typedef logic [2:0][7:0] byte3_t;

    // Whole state of the block, registered as one word
    typedef struct packed {
        logic [7:0] adapt_ctrl;
        logic [7:0] ramp_one;
        logic [7:0] ramp_two;
        byte3_t     lim_hi;
        byte3_t     lim_lo;
        byte3_t     op_point;
        byte3_t     threshold;
        byte3_t     duty;
        logic [1:0] alert_sync;
        logic       alert_seen;
        logic [7:0] rdata;
    } state_t;
endpackage

// >>> fan_adapt.sv
// Turn-on threshold adaptation, alert capture and duty ramping for three fans.
// Assumes temperatures and duty targets arrive from logic on CLK_SYS; the
// alert pin is asynchronous and is synchronised here.
`include "fan_adapt_regs.svh"

module fan_adapt #(
    parameter int DUTY_W = 8
) (
    // Clock and reset
    input  wire logic              CLK_SYS,
    input  wire logic              NRST,
    // Register port
    input  wire logic [7:0]        ADDR,
    input  wire logic [7:0]        WDATA,
    input  wire logic              WR,
    input  wire logic              RD,
    output logic      [7:0]        RDATA,
    // Temperature source, index 0 far 1, 1 near, 2 far 2
    input  wire logic [2:0][7:0]   TEMP,
    input  wire logic              TEMP_DONE,
    // Alert pin, low when asserted
    input  wire logic              THERMAL_ALERT_N,
    // Duty targets from the speed curve, one per fan drive
    input  wire logic [2:0][7:0]   DUTY_TARGET,
    input  wire logic              DUTY_UPDATE,
    // Outputs
    output logic      [2:0][7:0]   FAN_DRIVE,
    output logic      [2:0][7:0]   TURN_ON_THRESHOLD,
    output logic      [2:0]        FAN_HOLD_OFF
);

    // The ramp arithmetic is written for eight-bit slot counts only
    if (DUTY_W != 8) begin : g_bad_width
        $error("fan_adapt supports DUTY_W of 8 only");
    end

    fan_adapt_pkg::state_t q;
    fan_adapt_pkg::state_t d;

    logic       alert_edge;
    logic [2:0] cap_en;
    logic [2:0] adp_en;
    logic [2:0] ramp_en;
    logic [2:0][2:0] step_code;
    logic [2:0] below_thr;

    // Step size in slots for each ramp code
    function automatic logic [7:0] step_slots(input logic [2:0] code);
        case (code)
            3'h0:    step_slots = `STEP_0;
            3'h1:    step_slots = `STEP_1;
            3'h2:    step_slots = `STEP_2;
            3'h3:    step_slots = `STEP_3;
            3'h4:    step_slots = `STEP_4;
            3'h5:    step_slots = `STEP_5;
            3'h6:    step_slots = `STEP_6;
            default: step_slots = `STEP_7;
        endcase
    endfunction

    // One ramp step, clamped on the target so the output cannot hunt around it
    function automatic logic [7:0] ramp_step(input logic [7:0] cur,
                                             input logic [7:0] tgt,
                                             input logic [2:0] code);
        logic [7:0] st;
        st = step_slots(code);
        if (tgt > cur) begin
            ramp_step = ((tgt - cur) <= st) ? tgt : 8'(cur + st);
        end else if (tgt < cur) begin
            ramp_step = ((cur - tgt) <= st) ? tgt : 8'(cur - st);
        end else begin
            ramp_step = cur;
        end
    endfunction

    // Field decode of the control registers
    always_comb begin
        cap_en       = {q.adapt_ctrl[`BIT_CAP_F2], q.adapt_ctrl[`BIT_CAP_NR],
                        q.adapt_ctrl[`BIT_CAP_F1]};
        adp_en       = {q.adapt_ctrl[`BIT_ADP_F2], q.adapt_ctrl[`BIT_ADP_NR],
                        q.adapt_ctrl[`BIT_ADP_F1]};
        ramp_en[0]   = q.ramp_one[`BIT_RAMP_EN_LO];
        ramp_en[1]   = q.ramp_two[`BIT_RAMP_EN_HI];
        ramp_en[2]   = q.ramp_two[`BIT_RAMP_EN_LO];
        step_code[0] = q.ramp_one[`FLD_STEP_LO];
        step_code[1] = q.ramp_two[`FLD_STEP_HI];
        step_code[2] = q.ramp_two[`FLD_STEP_LO];
    end

    // Alert is active low; only the second sync stage is looked at
    assign alert_edge = !q.alert_sync[1] && !q.alert_seen;

    // Channel below its threshold keeps the fan off
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            below_thr[i] = $signed(TEMP[i]) < $signed(q.threshold[i]);
        end
    end

    // Next-state logic for the whole block
    always_comb begin
        d = q;
        d.alert_sync = {q.alert_sync[0], THERMAL_ALERT_N};
        d.alert_seen = !q.alert_sync[1];
        d.rdata      = 8'h00;

        // Software writes; hardware updates below take priority on collision
        if (WR) begin
            case (ADDR)
                `ADDR_ADAPT_CTRL: d.adapt_ctrl   = WDATA;
                `ADDR_RAMP_ONE:   d.ramp_one     = WDATA;
                `ADDR_RAMP_TWO:   d.ramp_two     = WDATA;
                `ADDR_LIM_LO_F1:  d.lim_lo[0]    = WDATA;
                `ADDR_LIM_HI_F1:  d.lim_hi[0]    = WDATA;
                `ADDR_LIM_LO_NR:  d.lim_lo[1]    = WDATA;
                `ADDR_LIM_HI_NR:  d.lim_hi[1]    = WDATA;
                `ADDR_LIM_LO_F2:  d.lim_lo[2]    = WDATA;
                `ADDR_LIM_HI_F2:  d.lim_hi[2]    = WDATA;
                default: begin
                    for (int i = 0; i < 3; i++) begin
                        if (ADDR == 8'(`ADDR_OP_BASE + i)) begin
                            d.op_point[i] = WDATA;
                        end
                        if (ADDR == 8'(`ADDR_THR_BASE + i)) begin
                            d.threshold[i] = WDATA;
                        end
                    end
                end
            endcase
        end

        // Register reads, answered in the next cycle only
        if (RD) begin
            case (ADDR)
                `ADDR_ADAPT_CTRL: d.rdata = q.adapt_ctrl;
                `ADDR_RAMP_ONE:   d.rdata = q.ramp_one;
                `ADDR_RAMP_TWO:   d.rdata = q.ramp_two;
                `ADDR_LIM_LO_F1:  d.rdata = q.lim_lo[0];
                `ADDR_LIM_HI_F1:  d.rdata = q.lim_hi[0];
                `ADDR_LIM_LO_NR:  d.rdata = q.lim_lo[1];
                `ADDR_LIM_HI_NR:  d.rdata = q.lim_hi[1];
                `ADDR_LIM_LO_F2:  d.rdata = q.lim_lo[2];
                `ADDR_LIM_HI_F2:  d.rdata = q.lim_hi[2];
                `ADDR_STATUS:     d.rdata = {4'h0, q.alert_sync[1], below_thr};
                default: begin
                    for (int i = 0; i < 3; i++) begin
                        if (ADDR == 8'(`ADDR_OP_BASE + i)) begin
                            d.rdata = q.op_point[i];
                        end
                        if (ADDR == 8'(`ADDR_THR_BASE + i)) begin
                            d.rdata = q.threshold[i];
                        end
                        if (ADDR == 8'(`ADDR_DUTY_BASE + i)) begin
                            d.rdata = q.duty[i];
                        end
                    end
                end
            endcase
        end

        for (int i = 0; i < 3; i++) begin
            // Alert capture of the latest converted temperature
            if (alert_edge && cap_en[i]) begin
                d.op_point[i] = TEMP[i];
            end
            // Disabled capture leaves the software value untouched
            // Adaptation step, only above threshold and only when enabled
            if (TEMP_DONE && adp_en[i] && !below_thr[i]) begin
                if ($signed(TEMP[i]) > $signed(q.op_point[i])) begin
                    if ($signed(q.threshold[i]) > $signed(`TEMP_FLOOR)) begin
                        d.threshold[i] = 8'(q.threshold[i] - `THR_STEP);
                    end
                end else if ($signed(TEMP[i]) < $signed(q.lim_lo[i]) &&
                             $signed(q.threshold[i]) < $signed(q.lim_hi[i]) &&
                             $signed(q.threshold[i]) < $signed(q.op_point[i])) begin
                    d.threshold[i] = 8'(q.threshold[i] + `THR_STEP);
                end
            end
            // Duty update, direct or ramped per output
            if (DUTY_UPDATE) begin
                if (ramp_en[i]) begin
                    d.duty[i] = ramp_step(q.duty[i], DUTY_TARGET[i], step_code[i]);
                end else begin
                    d.duty[i] = DUTY_TARGET[i];
                end
            end
        end
    end

    // State register; a slot count is a plain 0..255 value
    always_ff @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            q.adapt_ctrl <= 8'h00;
            q.ramp_one   <= 8'h00;
            q.ramp_two   <= 8'h00;
            q.lim_hi     <= {3{`LIM_HI_RESET}};
            q.lim_lo     <= {3{`LIM_LO_RESET}};
            q.op_point   <= {3{`OP_RESET}};
            q.threshold  <= {3{`THR_RESET}};
            q.duty       <= {3{`DUTY_FULL}};
            q.alert_sync <= 2'h3;
            q.alert_seen <= 1'b0;
            q.rdata      <= 8'h00;
        end else begin
            q <= d;
        end
    end

    // Outputs
    assign RDATA             = q.rdata;
    assign FAN_DRIVE         = q.duty;
    assign TURN_ON_THRESHOLD = q.threshold;
    assign FAN_HOLD_OFF      = below_thr;

    // Checks
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!NRST);

    sequence s_alert_fall;
        THERMAL_ALERT_N ##1 !THERMAL_ALERT_N [*3];
    endsequence

    a_threshold_floor: assert property (
        $signed(q.threshold[0]) >= $signed(`TEMP_FLOOR) || !$changed(q.threshold[0])
        || $past(WR)) else $error("threshold fell below floor");
    a_threshold_ceiling: assert property (
        (TEMP_DONE && !WR && $signed(q.threshold[1]) >= $signed(q.lim_hi[1]))
        |=> $signed(q.threshold[1]) <= $signed($past(q.threshold[1])))
        else $error("threshold rose above high limit");
    a_below_frozen: assert property (
        (below_thr[2] && !WR) |=> q.threshold[2] == $past(q.threshold[2]))
        else $error("threshold adapted below threshold");
    a_capture_far2: assert property (
        (s_alert_fall ##0 (cap_en[2] && !q.alert_seen && !q.alert_sync[1]))
        |=> q.op_point[2] == $past(TEMP[2])) else $error("far 2 capture missed");
    a_capture_off: assert property (
        (alert_edge && !cap_en[1] && !WR) |=> $stable(q.op_point[1]))
        else $error("capture happened while disabled");
    a_adapt_off: assert property (
        (!adp_en[0] && !WR) |=> $stable(q.threshold[0]))
        else $error("threshold changed with adaptation off");
    a_direct_duty: assert property (
        (DUTY_UPDATE && !ramp_en[1]) |=> FAN_DRIVE[1] == $past(DUTY_TARGET[1]))
        else $error("direct duty not applied");
    a_ramp_bound: assert property (
        (DUTY_UPDATE && ramp_en[0]) |=>
        (FAN_DRIVE[0] - $past(FAN_DRIVE[0]) <= 8'h30 ||
         $past(FAN_DRIVE[0]) - FAN_DRIVE[0] <= 8'h30))
        else $error("ramp step too large");
    a_ramp_hold: assert property (
        !DUTY_UPDATE |=> $stable(FAN_DRIVE[2])) else $error("duty moved without update");

    // Per-channel checks; each guards one step of the adaptation, alert capture or ramp rules.
    // The named sequences below say when a channel or drive is live at all,
    // so that each property that uses one only has to add its own condition.
    sequence s_adapt_live0;
        TEMP_DONE && adp_en[0] && !below_thr[0] && !WR;
    endsequence

    sequence s_adapt_live2;
        TEMP_DONE && adp_en[2] && !below_thr[2] && !WR;
    endsequence

    sequence s_ramp_upd0;
        DUTY_UPDATE && ramp_en[0];
    endsequence

    sequence s_ramp_upd1;
        DUTY_UPDATE && ramp_en[1];
    endsequence

    // A channel sitting on the floor stays there however hot it runs
    a_floor_sticks: assert property (
        (s_adapt_live0 ##0 (q.threshold[0] == `TEMP_FLOOR))
        |=> q.threshold[0] == `TEMP_FLOOR)
        else $error("threshold left the floor");

    // A hot far 1 channel loses one degree per conversion above the floor
    a_far1_lowers: assert property (
        (s_adapt_live0 ##0 ($signed(TEMP[0]) > $signed(q.op_point[0]) &&
                            $signed(q.threshold[0]) > $signed(`TEMP_FLOOR)))
        |=> q.threshold[0] == 8'($past(q.threshold[0]) - `THR_STEP))
        else $error("far 1 threshold did not fall");

    // A cool far 2 channel gains one degree while below limit and operating point
    a_far2_raises: assert property (
        (s_adapt_live2 ##0 ($signed(TEMP[2]) <= $signed(q.op_point[2]) &&
                            $signed(TEMP[2]) < $signed(q.lim_lo[2]) &&
                            $signed(q.threshold[2]) < $signed(q.lim_hi[2]) &&
                            $signed(q.threshold[2]) < $signed(q.op_point[2])))
        |=> q.threshold[2] == 8'($past(q.threshold[2]) + `THR_STEP))
        else $error("far 2 threshold did not rise");

    // Once at the high limit, far 2 never climbs further
    a_far2_ceiling: assert property (
        (s_adapt_live2 ##0 ($signed(q.threshold[2]) >= $signed(q.lim_hi[2])))
        |=> $signed(q.threshold[2]) <= $signed($past(q.threshold[2])))
        else $error("far 2 threshold passed high limit");

    // Near channel with adaptation off keeps what software wrote
    a_near_frozen: assert property (
        (!adp_en[1] && !WR) |=> $stable(q.threshold[1]))
        else $error("near threshold changed with adaptation off");

    // Below its threshold the near channel does not adapt either
    a_near_below: assert property (
        (below_thr[1] && !WR) |=> $stable(q.threshold[1]))
        else $error("near threshold adapted below threshold");

    // A low pin seen for three samples after a high one always makes one edge
    a_alert_low_edge: assert property (
        (s_alert_fall ##0 !q.alert_seen) |-> alert_edge)
        else $error("low alert pin not taken");

    // One capture per assertion: the edge never repeats on the next cycle
    a_alert_single: assert property (
        alert_edge |=> !alert_edge)
        else $error("alert edge repeated");

    // Enabled captures on near and far 1 take the temperature of that cycle
    a_capture_near: assert property (
        (alert_edge && cap_en[1]) |=> q.op_point[1] == $past(TEMP[1]))
        else $error("near capture missed");
    a_capture_far1: assert property (
        (alert_edge && cap_en[0]) |=> q.op_point[0] == $past(TEMP[0]))
        else $error("far 1 capture missed");

    // Disabled capture on far 2 leaves its operating point alone
    a_capture_off_far2: assert property (
        (alert_edge && !cap_en[2] && !WR) |=> $stable(q.op_point[2]))
        else $error("far 2 captured while disabled");

    // A ramped drive rising moves up but never past its target
    a_ramp_rises: assert property (
        (s_ramp_upd0 ##0 (DUTY_TARGET[0] > FAN_DRIVE[0]))
        |=> (FAN_DRIVE[0] > $past(FAN_DRIVE[0]) &&
             FAN_DRIVE[0] <= $past(DUTY_TARGET[0])))
        else $error("ramp up wrong");

    // A ramped drive falling moves down at once but never below its target
    a_ramp_falls: assert property (
        (s_ramp_upd0 ##0 (DUTY_TARGET[0] < FAN_DRIVE[0]))
        |=> (FAN_DRIVE[0] < $past(FAN_DRIVE[0]) &&
             FAN_DRIVE[0] >= $past(DUTY_TARGET[0])))
        else $error("ramp down wrong");

    // Widest code far from target moves exactly its full step
    a_ramp_widest: assert property (
        (s_ramp_upd1 ##0 (step_code[1] == 3'h7 &&
                          {1'b0, FAN_DRIVE[1]} + 9'(`STEP_7) < {1'b0, DUTY_TARGET[1]}))
        |=> FAN_DRIVE[1] == 8'($past(FAN_DRIVE[1]) + `STEP_7))
        else $error("widest ramp step wrong");

    // Drives without ramping take the target at once
    a_direct_far3: assert property (
        (DUTY_UPDATE && !ramp_en[2]) |=> FAN_DRIVE[2] == $past(DUTY_TARGET[2]))
        else $error("drive 3 direct duty not applied");
    a_direct_far1: assert property (
        (DUTY_UPDATE && !ramp_en[0]) |=> FAN_DRIVE[0] == $past(DUTY_TARGET[0]))
        else $error("drive 1 direct duty not applied");

    // Drive 1 holds its duty between updates
    a_ramp_hold_far1: assert property (
        !DUTY_UPDATE |=> $stable(FAN_DRIVE[0]))
        else $error("drive 1 moved without update");

endmodule // fan_adapt

// >>> fan_adapt_tb.sv
// Self-checking bench for the fan threshold block: registers, ramping,
// alert capture and threshold adaptation. Drives every port of the block
// directly; assumes the register map of the block's header file.
`include "fan_adapt_regs.svh"

module testbench;
    timeunit 1ns;
    timeprecision 100ps;

    logic              clk_sys;
    logic              nrst;
    logic [7:0]        addr;
    logic [7:0]        wdata;
    logic              wr_en;
    logic              rd_en;
    logic [7:0]        rdata;
    logic [2:0][7:0]   temp;
    logic              temp_done;
    logic              alert_n;
    logic [2:0][7:0]   duty_target;
    logic              duty_update;
    logic [2:0][7:0]   fan_drive;
    logic [2:0][7:0]   threshold;
    logic [2:0]        hold_off;
    int                err_count;
    int                samples_checked;
    int                cycles;
    int                k;
    logic [7:0]        steps [8] = '{8'h01, 8'h02, 8'h03, 8'h05, 8'h08, 8'h0C, 8'h18, 8'h30};

    fan_adapt i_dut (
        .CLK_SYS(clk_sys), .NRST(nrst), .ADDR(addr), .WDATA(wdata), .WR(wr_en), .RD(rd_en),
        .RDATA(rdata), .TEMP(temp), .TEMP_DONE(temp_done), .THERMAL_ALERT_N(alert_n),
        .DUTY_TARGET(duty_target), .DUTY_UPDATE(duty_update), .FAN_DRIVE(fan_drive),
        .TURN_ON_THRESHOLD(threshold), .FAN_HOLD_OFF(hold_off)
    );

    // 200 MHz system clock
    always #2.5 clk_sys = ~clk_sys;

    // Cuts a hang short; the whole run needs well under a thousand cycles
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 3000) begin
            err_count++;
            finish_test();
        end
    end

    task automatic finish_test();
        if (err_count == 0 && samples_checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
            err_count++;
        end
    endtask

    task automatic chk3(input string nm, input logic [2:0][7:0] seen, input logic [2:0][7:0] e);
        for (int i = 0; i < 3; i++) chk(nm, seen[i], e[i]);
    endtask

    // One-cycle write strobe, released at the next edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        addr  <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clk_sys);
        wr_en <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe, so sample there
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk_sys);
        addr  <= a;
        rd_en <= 1'b1;
        @(posedge clk_sys);
        rd_en <= 1'b0;
        #1 chk("rdata", rdata, e);
    endtask

    // New duty targets with one update pulse; drives settle one cycle later
    task automatic upd(input logic [2:0][7:0] t, input logic [2:0][7:0] e);
        @(posedge clk_sys);
        duty_target <= t;
        duty_update <= 1'b1;
        @(posedge clk_sys);
        duty_update <= 1'b0;
        #1 chk3("fan_drive", fan_drive, e);
    endtask

    // One finished conversion, then the thresholds it produced
    task automatic tick(input logic [2:0][7:0] e);
        @(posedge clk_sys);
        temp_done <= 1'b1;
        @(posedge clk_sys);
        temp_done <= 1'b0;
        #1 chk3("threshold", threshold, e);
    endtask

    // Alert held low long enough to pass the synchroniser, then released
    task automatic alert_pulse();
        @(posedge clk_sys);
        alert_n <= 1'b0;
        repeat (5) @(posedge clk_sys);
        alert_n <= 1'b1;
        repeat (4) @(posedge clk_sys);
    endtask

    // Main sequence
    initial begin
        clk_sys = 1'b0; nrst = 1'b0; addr = 8'h00; wdata = 8'h00; wr_en = 1'b0;
        rd_en = 1'b0; temp = '0; temp_done = 1'b0; alert_n = 1'b1;
        duty_target = '0; duty_update = 1'b0; err_count = 0; samples_checked = 0; cycles = 0;
        repeat (3) @(posedge clk_sys);
        nrst <= 1'b1;
        #1 chk3("fan_drive", fan_drive, {3{`DUTY_FULL}});
        rd(`ADDR_ADAPT_CTRL, 8'h00);
        rd(`ADDR_RAMP_ONE, 8'h00);
        rd(`ADDR_RAMP_TWO, 8'h00);
        rd(`ADDR_THR_BASE, `THR_RESET);
        rd(`ADDR_OP_BASE, `OP_RESET);
        rd(`ADDR_LIM_LO_F1, `LIM_LO_RESET);
        rd(`ADDR_LIM_HI_F2, `LIM_HI_RESET);
        // Unmapped place: write dropped, read gives zero
        wr(8'h01, 8'hAA);
        rd(8'h01, 8'h00);
        upd({3{8'h10}}, {3{8'h10}});
        // Every step code on all three drives: one step up, then straight back down
        for (k = 0; k < 8; k++) begin
            wr(`ADDR_RAMP_ONE, {5'h01, k[2:0]});
            wr(`ADDR_RAMP_TWO, {1'b1, k[2:0], 1'b1, k[2:0]});
            upd({3{8'hF0}}, {3{8'h10 + steps[k]}});
            upd({3{8'h00}}, {3{8'h10}});
        end
        rd(`ADDR_RAMP_TWO, 8'hFF);
        upd({3{8'h20}}, {3{8'h20}});
        upd({3{8'h10}}, {3{8'h10}});
        // Only drive 2 ramps while all three share one target
        wr(`ADDR_RAMP_ONE, 8'h00);
        wr(`ADDR_RAMP_TWO, 8'hF0);
        upd({3{8'hF0}}, {8'hF0, 8'h40, 8'hF0});
        rd(`ADDR_DUTY_BASE + 8'h01, 8'h40);
        // Alert capture on the two far channels only, then on the near channel only
        wr(`ADDR_ADAPT_CTRL, 8'h14);
        temp <= {8'h56, 8'h34, 8'h12};
        alert_pulse();
        rd(`ADDR_OP_BASE, 8'h12);
        rd(`ADDR_OP_BASE + 8'h01, `OP_RESET);
        rd(`ADDR_OP_BASE + 8'h02, 8'h56);
        wr(`ADDR_ADAPT_CTRL, 8'h08);
        temp <= {8'h66, 8'h44, 8'h22};
        alert_pulse();
        rd(`ADDR_OP_BASE + 8'h01, 8'h44);
        rd(`ADDR_OP_BASE, 8'h12);
        rd(`ADDR_OP_BASE + 8'h02, 8'h56);
        // Adaptation: far 1 falls to the floor, near is off, far 2 rises to its high limit
        wr(`ADDR_ADAPT_CTRL, 8'hA0);
        wr(`ADDR_THR_BASE, 8'h82);
        wr(`ADDR_OP_BASE, 8'h00);
        wr(`ADDR_OP_BASE + 8'h01, 8'h00);
        wr(`ADDR_THR_BASE + 8'h02, 8'h10);
        wr(`ADDR_LIM_HI_F2, 8'h11);
        wr(`ADDR_LIM_LO_F2, 8'h20);
        wr(`ADDR_OP_BASE + 8'h02, 8'h40);
        temp <= {8'h15, 8'h60, 8'h10};
        tick({8'h11, `THR_RESET, `TEMP_FLOOR});
        tick({8'h11, `THR_RESET, `TEMP_FLOOR});
        chk("hold_off", 8'(hold_off), 8'h00);
        // Below threshold: fan held off and adaptation stopped
        wr(`ADDR_LIM_HI_F2, 8'h30);
        temp <= {8'h05, 8'h50, 8'h10};
        #1 chk("hold_off", 8'(hold_off), 8'h06);
        tick({8'h11, `THR_RESET, `TEMP_FLOOR});
        rd(`ADDR_STATUS, 8'h0E);
        finish_test();
    end
endmodule // testbench
